// file: src/arw_readout_window.sv
// Read-out window of the ambient light sample queue.
// Assumes a same-clock register port from the two-wire serial engine
// and a same-clock source of finished data sets.
`timescale 1ns/1ps
module arw_readout_window #(
   parameter int DEPTH = 16
) (
   input wire logic mclk,
   input wire logic rst_n,
   // Configuration
   input wire logic paired_channel_select,
   input wire logic sample_width_8,
   // Register port from the serial engine
   input wire logic reg_ptr_load,
   input wire logic [7:0] reg_ptr_value,
   input wire logic reg_rd,
   output logic [7:0] reg_rd_data,
   output logic reg_rd_valid,
   // Data sets from the measurement side
   input wire logic samp_valid,
   input wire logic [arw_pkg::SET_W-1:0] samp_data,
   output logic samp_ready,
   // Queue control and status
   input wire logic sample_queue_clear,
   output logic [arw_pkg::LVL_W-1:0] sample_queue_level,
   output logic sample_queue_empty,
   output logic sample_queue_overflow_flag
);
   import arw_pkg::*;

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (DEPTH < 2 || DEPTH > 128) begin : g_bad_depth
      $error("arw_readout_window depth must lie in 2 to 128");
   end

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   arw_fifo_if #(.WIDTH(SET_W), .LVL_W(LVL_W)) q_if ();

   arw_win_state_t win_state_reg; // Whether a set is held
   logic [SET_W-1:0] image_reg; // Eight window bytes, byte 0 lowest
   logic [7:0] ptr_reg; // Auto-incrementing register pointer
   logic [7:0] addr_now; // Address used by this cycle's read
   logic in_window; // Address lies in F8..FF
   logic [2:0] byte_idx; // 0 for FF up to 7 for F8
   logic last_read; // Host read of the last register
   logic take_set; // Window takes the queue head now
   logic [7:0] wrap_to; // Resume point after FF
   logic [7:0] rd_data_reg;
   logic rd_valid_reg;
   logic [LVL_W-1:0] level_reg;
   logic empty_reg;
   logic ovf_reg;
   logic [SET_W-1:0] image_next; // Mapped image of the queue head

   // ------------------------------------------------------------
   // Mapping of one data set onto the eight window bytes
   // ------------------------------------------------------------
   // Bytes that a mode leaves undefined are built as zero, so a
   // read of them needs no separate mask in the read path.
   function automatic logic [SET_W-1:0] arw_map(
      input logic [SET_W-1:0] s,
      input logic two,
      input logic narrow
   );
      logic [15:0] b;
      logic [15:0] g;
      logic [15:0] r;
      logic [15:0] c;
      logic [15:0] rb;
      logic [15:0] cg;
      logic [SET_W-1:0] img;
      b = s[BLUE_LSB +: 16];
      g = s[GREEN_LSB +: 16];
      r = s[RED_LSB +: 16];
      c = s[CLEAR_LSB +: 16];
      rb = s[RB_LSB +: 16];
      cg = s[CG_LSB +: 16];
      img = IMAGE_RESET;
      if (!two && !narrow) begin
         // Low byte at the lower address of each pair
         img = {b[7:0], b[15:8], g[7:0], g[15:8],
                r[7:0], r[15:8], c[7:0], c[15:8]};
      end else if (!two) begin
         img[31:0] = {b[7:0], g[7:0], r[7:0], c[7:0]};
      end else if (!narrow) begin
         img[31:0] = {rb[7:0], rb[15:8], cg[7:0], cg[15:8]};
      end else begin
         img[15:0] = {rb[7:0], cg[7:0]};
      end
      return img;
   endfunction : arw_map

   // ------------------------------------------------------------
   // Sample queue
   // ------------------------------------------------------------
   arw_fifo #(
      .WIDTH(SET_W),
      .DEPTH(DEPTH)
   ) u_queue (
      .mclk(mclk),
      .rst_n(rst_n),
      .q(q_if.fifo_side)
   );

   // Offered sets go straight in; the queue refuses them when full
   assign q_if.wr_valid = samp_valid;
   assign q_if.wr_data = samp_data;
   assign q_if.clear = sample_queue_clear;
   assign q_if.rd_ready = take_set;
   // Source sees back-pressure from the queue's full flop
   assign samp_ready = q_if.wr_ready;

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   // A pointer load and a read in one cycle read the new address
   always_comb begin
      if (reg_ptr_load) begin
         addr_now = reg_ptr_value;
      end else begin
         addr_now = ptr_reg;
      end
   end

   assign in_window = (addr_now >= ADDR_BYTE_7);
   assign byte_idx = 3'(ADDR_BYTE_0 - addr_now);
   assign last_read = reg_rd && (addr_now == ADDR_BYTE_0);

   // Window takes a new set when the last byte is read, or when it
   // holds nothing and data has arrived; a clear suppresses both.
   assign take_set = !sample_queue_clear && q_if.rd_valid
                     && (last_read || win_state_reg == ARW_WIN_IDLE);
   assign image_next = arw_map(q_if.rd_data, paired_channel_select,
                               sample_width_8);

   // ------------------------------------------------------------
   // Wrap point for block reads
   // ------------------------------------------------------------
   // Resume at the highest defined byte of the active mode
   always_comb begin
      if (!paired_channel_select && !sample_width_8) begin
         wrap_to = WRAP_4CH16;
      end else if (!paired_channel_select) begin
         wrap_to = WRAP_4CH8;
      end else if (!sample_width_8) begin
         wrap_to = WRAP_2CH16;
      end else begin
         wrap_to = WRAP_2CH8;
      end
   end

   // ------------------------------------------------------------
   // Register pointer
   // ------------------------------------------------------------
   // Each read advances; reading FF wraps instead of rolling to 00
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ptr_reg <= ADDR_BYTE_7;
      end else if (reg_rd && addr_now == ADDR_BYTE_0) begin
         ptr_reg <= wrap_to;
      end else if (reg_rd) begin
         ptr_reg <= addr_now + 8'h01;
      end else if (reg_ptr_load) begin
         ptr_reg <= reg_ptr_value;
      end
   end

   // ------------------------------------------------------------
   // Window image and holding state
   // ------------------------------------------------------------
   // The image changes only on a last-byte read, on first arrival
   // into an idle window, or on a clear.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         image_reg <= IMAGE_RESET;
         win_state_reg <= ARW_WIN_IDLE;
      end else if (sample_queue_clear) begin
         image_reg <= IMAGE_RESET;
         win_state_reg <= ARW_WIN_IDLE;
      end else if (take_set) begin
         image_reg <= image_next;
         win_state_reg <= ARW_WIN_HELD;
      end else if (last_read) begin
         // Nothing queued behind the read set: show zeros
         image_reg <= IMAGE_RESET;
         win_state_reg <= ARW_WIN_IDLE;
      end
      // Otherwise the held set stays untouched
   end

   // ------------------------------------------------------------
   // Read data path
   // ------------------------------------------------------------
   // Data is the image before any update in the same cycle, so the
   // last byte returns the old set and the load follows it.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rd_data_reg <= DATA_RESET;
         rd_valid_reg <= 1'b0;
      end else begin
         rd_valid_reg <= reg_rd;
         if (reg_rd && in_window) begin
            rd_data_reg <= image_reg[{byte_idx, 3'b000} +: 8];
         end else if (reg_rd) begin
            // Addresses outside the window are not this block's
            rd_data_reg <= DATA_RESET;
         end
      end
   end

   // ------------------------------------------------------------
   // Queue status
   // ------------------------------------------------------------
   // Level counts whole sets, one queue word per set
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         level_reg <= '0;
         empty_reg <= EMPTY_RESET;
      end else begin
         level_reg <= q_if.level;
         empty_reg <= (q_if.level == '0);
      end
   end

   // Overflow: a set offered while full is lost. A clear or a
   // last-byte read clears the flag, but a drop in that same cycle
   // wins so no loss goes unreported.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ovf_reg <= OVF_RESET;
      end else if (samp_valid && !q_if.wr_ready) begin
         ovf_reg <= 1'b1;
      end else if (sample_queue_clear || last_read) begin
         ovf_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign reg_rd_data = rd_data_reg;
   assign reg_rd_valid = rd_valid_reg;
   assign sample_queue_level = level_reg;
   assign sample_queue_empty = empty_reg;
   assign sample_queue_overflow_flag = ovf_reg;

endmodule : arw_readout_window

// file: inc/arw_pkg.sv
// Shared constants for the ambient light read-out window and its queue.
// Assumes one 40 MHz clock and a same-clock register port from the
// two-wire serial engine.
package arw_pkg;

   // ------------------------------------------------------------
   // Queue geometry
   // ------------------------------------------------------------
   localparam int SET_W = 64; // One data set, four 16-bit fields
   localparam int FIFO_DEPTH = 16; // Data sets held in the queue
   localparam int LVL_W = 8; // Width of the reported fill level

   // ------------------------------------------------------------
   // Register addresses of the read-out window
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_BYTE_7 = 8'hF8; // Highest window byte
   localparam logic [7:0] ADDR_BYTE_3 = 8'hFC;
   localparam logic [7:0] ADDR_BYTE_1 = 8'hFE;
   localparam logic [7:0] ADDR_BYTE_0 = 8'hFF; // Last byte, advances set

   // Block read resume points, one per configuration
   localparam logic [7:0] WRAP_4CH16 = 8'hF8;
   localparam logic [7:0] WRAP_4CH8 = 8'hFC;
   localparam logic [7:0] WRAP_2CH16 = 8'hFC;
   localparam logic [7:0] WRAP_2CH8 = 8'hFE;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [SET_W-1:0] IMAGE_RESET = 64'h0000000000000000;
   localparam logic EMPTY_RESET = 1'b1;
   localparam logic OVF_RESET = 1'b0;

   // ------------------------------------------------------------
   // Field positions inside an incoming data set
   // ------------------------------------------------------------
   localparam int BLUE_LSB = 48;
   localparam int GREEN_LSB = 32;
   localparam int RED_LSB = 16;
   localparam int CLEAR_LSB = 0;
   localparam int RB_LSB = 16; // Red plus blue sum, paired mode
   localparam int CG_LSB = 0; // Clear plus green sum, paired mode

   // Window holding state
   typedef enum logic [1:0] {
      ARW_WIN_IDLE = 2'b00, // No set loaded
      ARW_WIN_HELD = 2'b01  // A set is held for the host
   } arw_win_state_t;

endpackage : arw_pkg

// file: inc/arw_fifo_if.sv
// Carrier between the read-out window and its sample queue.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface arw_fifo_if #(
   parameter int WIDTH = 64,
   parameter int LVL_W = 8
);
   logic wr_valid; // Sample offered
   logic wr_ready; // Queue can take it, from a flop
   logic [WIDTH-1:0] wr_data;
   logic rd_valid; // Head entry present
   logic rd_ready; // Head entry taken this cycle
   logic [WIDTH-1:0] rd_data; // Show-ahead head entry
   logic [LVL_W-1:0] level; // Sets held, registered
   logic clear; // Drop everything, pointers to zero

   modport fifo_side (
      input wr_valid, wr_data, rd_ready, clear,
      output wr_ready, rd_valid, rd_data, level
   );
   modport user_side (
      output wr_valid, wr_data, rd_ready, clear,
      input wr_ready, rd_valid, rd_data, level
   );
endinterface : arw_fifo_if

// file: src/arw_fifo.sv
// Sample queue of whole data sets for the read-out window.
// Assumes one clock, synchronous active-low reset, show-ahead reads.
`timescale 1ns/1ps
module arw_fifo #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 16
) (
   input wire logic mclk,
   input wire logic rst_n,
   arw_fifo_if.fifo_side q
);
   import arw_pkg::*;

   localparam int AW = $clog2(DEPTH);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("arw_fifo depth must be a power of two, at least 2");
   end
   if (WIDTH != $bits(q.wr_data) || AW + 1 > $bits(q.level)) begin : g_bad_w
      $error("arw_fifo parameters do not match the carrier");
   end

   logic [WIDTH-1:0] mem [DEPTH]; // Storage, one set per word
   logic [AW:0] wptr_reg; // Extra bit unused; count_reg tells full from empty
   logic [AW:0] rptr_reg;
   logic [AW:0] count_reg; // Sets held
   logic ready_reg; // Registered not-full, drives ready with no gate
   logic push;
   logic pop;

   // Full sets are refused here; the window flags the discard
   assign push = q.wr_valid && ready_reg;
   assign pop = q.rd_ready && (count_reg != '0);

   assign q.wr_ready = ready_reg;
   assign q.rd_valid = (count_reg != '0);
   assign q.rd_data = mem[rptr_reg[AW-1:0]];
   assign q.level = {{($bits(q.level)-AW-1){1'b0}}, count_reg};

   // ------------------------------------------------------------
   // Storage write
   // ------------------------------------------------------------
   // No reset on the array; unread words are never shown
   always_ff @(posedge mclk) begin
      if (push && !q.clear) begin
         mem[wptr_reg[AW-1:0]] <= q.wr_data;
      end
   end

   // ------------------------------------------------------------
   // Pointers, count and full
   // ------------------------------------------------------------
   // Clear beats both push and pop in the same cycle
   always_ff @(posedge mclk) begin
      if (!rst_n || q.clear) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         count_reg <= '0;
         ready_reg <= 1'b1;
      end else begin
         if (push) begin
            wptr_reg <= wptr_reg + 1'b1;
         end
         if (pop) begin
            rptr_reg <= rptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
            ready_reg <= (count_reg != (AW+1)'(DEPTH - 1));
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
            ready_reg <= 1'b1;
         end
      end
   end

endmodule : arw_fifo

// file: test/arw_readout_window_props.sv
// Port checker for the read-out window.
// Assumes it is bound onto arw_readout_window.
`timescale 1ns/1ps
module arw_readout_window_props
   import arw_pkg::*;
#(
   parameter int DEPTH = 16
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic paired_channel_select,
   input wire logic sample_width_8,
   input wire logic reg_ptr_load,
   input wire logic [7:0] reg_ptr_value,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rd_data,
   input wire logic reg_rd_valid,
   input wire logic samp_valid,
   input wire logic [arw_pkg::SET_W-1:0] samp_data,
   input wire logic samp_ready,
   input wire logic sample_queue_clear,
   input wire logic [arw_pkg::LVL_W-1:0] sample_queue_level,
   input wire logic sample_queue_empty,
   input wire logic sample_queue_overflow_flag
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // ----
   // Sequences
   // ----
   // A drop in the same cycle wins over any clearing
   sequence s_rd_last;
      reg_rd && reg_ptr_load && reg_ptr_value == 8'hFF
         && !(samp_valid && !samp_ready);
   endsequence
   sequence s_clear;
      sample_queue_clear && !(samp_valid && !samp_ready);
   endsequence
   property p_answer;
      reg_rd |=> reg_rd_valid;
   endproperty
   property p_hold;
      !reg_rd |=> !reg_rd_valid && $stable(reg_rd_data);
   endproperty
   property p_low_zero;
      reg_rd && reg_ptr_load && reg_ptr_value < 8'hF8
         |=> reg_rd_data == 8'h00;
   endproperty
   property p_ovf_set;
      samp_valid && !samp_ready |=> sample_queue_overflow_flag;
   endproperty
   property p_ovf_read;
      s_rd_last |=> !sample_queue_overflow_flag;
   endproperty
   property p_ovf_clear;
      s_clear |=> !sample_queue_overflow_flag;
   endproperty
   property p_sticky;
      sample_queue_overflow_flag && !reg_rd && !sample_queue_clear
         |=> sample_queue_overflow_flag;
   endproperty
   property p_empty;
      sample_queue_empty == (sample_queue_level == 8'h00);
   endproperty
   property p_clear_empty;
      s_clear ##1 !samp_valid[*3] |-> sample_queue_empty;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   a_hold: assert property (p_hold) else $error("data moved");
   a_low_zero: assert property (p_low_zero) else $error("nonzero");
   a_ovf_set: assert property (p_ovf_set) else $error("no ovf");
   a_ovf_read: assert property (p_ovf_read) else $error("ovf kept");
   a_ovf_clear: assert property (p_ovf_clear) else $error("ovf");
   a_sticky: assert property (p_sticky) else $error("ovf lost");
   a_empty: assert property (p_empty) else $error("empty flag");
   a_clear_empty: assert property (p_clear_empty) else $error("clr");
endmodule : arw_readout_window_props

// file: test/arw_host_model.sv
// Two-wire host model: register reads and queue clear.
// Assumes the window's same-clock register port.
`timescale 1ns/1ps
module arw_host_model (
   input wire logic mclk,
   input wire logic [7:0] reg_rd_data,
   input wire logic reg_rd_valid,
   output logic reg_ptr_load,
   output logic [7:0] reg_ptr_value,
   output logic reg_rd,
   output logic sample_queue_clear
);
   // Idle levels at time zero
   initial begin
      reg_ptr_load = 1'b0;
      reg_ptr_value = 8'h00;
      reg_rd = 1'b0;
      sample_queue_clear = 1'b0;
   end
   // One read; without a load the pointer auto-increments
   task automatic rd(input logic ld, input logic [7:0] a,
                     output logic [7:0] d, output logic v);
      @(negedge mclk);
      reg_ptr_load = ld;
      reg_ptr_value = a;
      reg_rd = 1'b1;
      @(negedge mclk);
      reg_rd = 1'b0;
      reg_ptr_load = 1'b0;
      // Released address toggles so stale values are not reused
      reg_ptr_value = ~reg_ptr_value;
      d = reg_rd_data;
      v = reg_rd_valid;
   endtask : rd
   // Clear only while no samples are offered
   task automatic clr;
      @(negedge mclk);
      sample_queue_clear = 1'b1;
      @(negedge mclk);
      sample_queue_clear = 1'b0;
   endtask : clr
endmodule : arw_host_model

// file: test/arw_readout_window_tb.sv
// Self-checking bench for the read-out window.
// Assumes arw_pkg, the queue and the host model are compiled first.
`timescale 1ns/1ps
module arw_readout_window_tb;
   import arw_pkg::*;
   localparam int DEPTH = 4; // Small queue keeps the fill test short
   localparam logic [SET_W-1:0] SA = 64'h8A7B6C5D4E3F2011;
   logic mclk, rst_n, two, narrow, samp_valid, samp_ready;
   logic [SET_W-1:0] samp_data;
   logic reg_ptr_load, reg_rd, reg_rd_valid, clr, empty, ovf, v;
   logic [7:0] reg_ptr_value, reg_rd_data, lvl, d, w;
   int mismatches, checks, cyc;
   arw_readout_window #(.DEPTH(DEPTH)) arw_readout_window_i (
      .mclk, .rst_n, .paired_channel_select(two),
      .sample_width_8(narrow), .reg_ptr_load, .reg_ptr_value, .reg_rd,
      .reg_rd_data, .reg_rd_valid, .samp_valid, .samp_data,
      .samp_ready, .sample_queue_clear(clr), .sample_queue_level(lvl),
      .sample_queue_empty(empty), .sample_queue_overflow_flag(ovf));
   arw_host_model arw_host_model_i (
      .mclk, .reg_rd_data, .reg_rd_valid, .reg_ptr_load,
      .reg_ptr_value, .reg_rd, .sample_queue_clear(clr));
   // ----
   // Clock and hang guard
   // ----
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin // Far above the expected run
         mismatches++;
         finish_test();
      end
   end
   task automatic chk8(input string n, input logic [7:0] e,
                       input logic [7:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask : chk8
   task automatic chk1(input string n, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %s expected %b seen %b", n, e, g);
      end
   endtask : chk1
   // Read and compare one byte
   task automatic rdc(input logic ld, input logic [7:0] a,
                      input logic [7:0] e);
      arw_host_model_i.rd(ld, a, d, v);
      chk1("rd_valid", 1'b1, v);
      chk8("rd_data", e, d);
   endtask : rdc
   // Offer one set for one cycle
   task automatic push(input logic [SET_W-1:0] s);
      @(negedge mclk);
      samp_valid = 1'b1;
      samp_data = s;
      @(negedge mclk);
      samp_valid = 1'b0;
      samp_data = ~s; // Released data does not stay valid-looking
   endtask : push
   // Byte expected at an address for the current mode
   function automatic logic [7:0] exp_b(logic [SET_W-1:0] s,
                                        logic [7:0] a);
      int f;
      int k;
      k = int'(a) - int'(8'hF8);
      f = narrow ? int'(8'hFF) - int'(a) : 3 - k / 2;
      if (k < 0 || f >= (two ? 2 : 4)) return 8'h00;
      return s[f*16 + (narrow ? 0 : (k % 2) * 8) +: 8];
   endfunction : exp_b
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finish_test
   // ----
   // Main sequence
   // ----
   initial begin
      rst_n = 1'b0;
      two = 1'b0;
      narrow = 1'b0;
      samp_valid = 1'b0;
      samp_data = '0;
      repeat (5) @(posedge mclk);
      @(negedge mclk) rst_n = 1'b1;
      chk1("empty", 1'b1, empty);
      chk8("level", 8'h00, lvl);
      chk1("ovf", 1'b0, ovf);
      for (int i = 0; i < 8; i++) rdc(i == 0, 8'hF8 + 8'(i), 8'h00);
      rdc(1'b1, 8'h10, 8'h00);
      // Every channel and width mode, block read with wrap
      for (int c = 0; c < 4; c++) begin
         two = c[1];
         narrow = c[0];
         arw_host_model_i.clr();
         push(SA);
         push(~SA);
         repeat (4) @(negedge mclk);
         rdc(1'b1, 8'hF8, exp_b(SA, 8'hF8));
         for (int i = 0; i < 8; i++)
            rdc(i == 0, 8'hF8 + 8'(i), exp_b(SA, 8'hF8 + 8'(i)));
         w = narrow ? (two ? 8'hFE : 8'hFC) : (two ? 8'hFC : 8'hF8);
         rdc(1'b0, w, exp_b(~SA, w));
      end
      // Fill until refused, then drain in order
      two = 1'b0;
      narrow = 1'b0;
      arw_host_model_i.clr();
      @(negedge mclk) samp_valid = 1'b1;
      for (int k = 0; k < DEPTH + 4; k++) begin
         samp_data = {4{8'(k), 8'hA5}};
         @(negedge mclk);
      end
      samp_valid = 1'b0;
      repeat (3) @(negedge mclk);
      chk8("level", 8'(DEPTH), lvl);
      chk1("ovf", 1'b1, ovf);
      chk1("samp_ready", 1'b0, samp_ready);
      for (int k = 0; k <= DEPTH; k++) rdc(1'b1, 8'hFF, 8'(k));
      rdc(1'b1, 8'hFF, 8'h00);
      repeat (3) @(negedge mclk);
      chk1("ovf", 1'b0, ovf);
      chk1("empty", 1'b1, empty);
      // Clear with sets pending
      push(SA);
      push(~SA);
      arw_host_model_i.clr();
      repeat (3) @(negedge mclk);
      chk8("level", 8'h00, lvl);
      chk1("empty", 1'b1, empty);
      rdc(1'b1, 8'hFE, 8'h00);
      // Mid-run reset with a set held must zero the window again
      push(SA);
      repeat (2) @(negedge mclk);
      rst_n = 1'b0;
      repeat (5) @(negedge mclk);
      rst_n = 1'b1;
      chk1("empty", 1'b1, empty);
      chk8("level", 8'h00, lvl);
      rdc(1'b1, 8'hFF, 8'h00);
      finish_test();
   end
endmodule : arw_readout_window_tb
bind arw_readout_window arw_readout_window_props #(.DEPTH(DEPTH)) props_i (
   .mclk, .rst_n, .paired_channel_select, .sample_width_8, .reg_ptr_load,
   .reg_ptr_value, .reg_rd, .reg_rd_data, .reg_rd_valid, .samp_valid,
   .samp_data, .samp_ready, .sample_queue_clear, .sample_queue_level,
   .sample_queue_empty, .sample_queue_overflow_flag);
